// ### rtl/cgs_pkg.sv
// Package for the CAN general status and interrupt bookkeeping block.
// Assumes an 8-bit register file reached over a plain strobe port.
package cgs_pkg;

  localparam int unsigned CGS_NUM_OBJ = 6;

  // Register offsets (word index on the plain port)
  localparam logic [3:0] CGS_OFS_STATUS    = 4'h0;
  localparam logic [3:0] CGS_OFS_GIFLAGS   = 4'h1;
  localparam logic [3:0] CGS_OFS_GIEN      = 4'h2;
  localparam logic [3:0] CGS_OFS_INUSE_LO  = 4'h3;
  localparam logic [3:0] CGS_OFS_INUSE_HI  = 4'h4;
  localparam logic [3:0] CGS_OFS_OIEN_LO   = 4'h5;
  localparam logic [3:0] CGS_OFS_OIEN_HI   = 4'h6;
  localparam logic [3:0] CGS_OFS_OIST_LO   = 4'h7;
  localparam logic [3:0] CGS_OFS_OIST_HI   = 4'h8;
  localparam logic [3:0] CGS_OFS_PRESCALE  = 4'h9;

  // Status register fields
  localparam int unsigned CGS_ST_ENABLE    = 2;
  localparam int unsigned CGS_ST_BUSOFF    = 1;
  localparam int unsigned CGS_ST_ERRPASS   = 0;

  // General interrupt flag fields
  localparam int unsigned CGS_GI_ANY       = 7;
  localparam int unsigned CGS_GI_BUSOFF    = 6;
  localparam int unsigned CGS_GI_TWRAP     = 5;
  localparam int unsigned CGS_GI_BUFRX     = 4;
  localparam int unsigned CGS_GI_STUFF     = 3;
  localparam int unsigned CGS_GI_CRC       = 2;
  localparam int unsigned CGS_GI_FORM      = 1;
  localparam int unsigned CGS_GI_ACK       = 0;

  // General interrupt enable fields
  localparam int unsigned CGS_IE_GLOBAL    = 7;
  localparam int unsigned CGS_IE_BUSOFF    = 6;
  localparam int unsigned CGS_IE_RX        = 5;
  localparam int unsigned CGS_IE_TX        = 4;
  localparam int unsigned CGS_IE_OBJERR    = 3;
  localparam int unsigned CGS_IE_BUF       = 2;
  localparam int unsigned CGS_IE_GENERR    = 1;
  localparam int unsigned CGS_IE_TWRAP     = 0;

  // Prescaler field, bits 6:1
  localparam int unsigned CGS_PS_LSB       = 1;
  localparam int unsigned CGS_PS_W         = 6;

  // Reset values
  localparam logic [7:0] CGS_RST_GIFLAGS   = 8'h00;
  localparam logic [7:0] CGS_RST_GIEN      = 8'h00;
  localparam logic [7:0] CGS_RST_OIEN      = 8'h00;
  localparam logic [7:0] CGS_RST_PRESCALE  = 8'h00;

  // Per-object events from the message-object logic
  typedef struct packed {
    logic [CGS_NUM_OBJ-1:0] rx_done;
    logic [CGS_NUM_OBJ-1:0] tx_done;
    logic [CGS_NUM_OBJ-1:0] err;
    logic [CGS_NUM_OBJ-1:0] cfg_on;
    logic [CGS_NUM_OBJ-1:0] cfg_off;
  } cgs_obj_ev_t;

  // Channel events from the bus engine, one-cycle pulses
  typedef struct packed {
    logic stuff_fault;
    logic crc_fault;
    logic form_fault;
    logic ack_fault;
    logic timer_wrap;
    logic buf_rx_done;
    logic buf_cfg_rewritten;
  } cgs_chan_ev_t;

endpackage

// ### rtl/cgs_quantum_gen.sv
// Time-quantum tick generator driven by the prescaler field.
// Assumes it shares the I/O clock and enable of the status block.
`timescale 1ns/1ps
`default_nettype none

module cgs_quantum_gen
  import cgs_pkg::*;
#(
  parameter int unsigned PS_W = CGS_PS_W
) (
  input  wire logic            clk_sys_i,
  input  wire logic            rst_n_i,
  input  wire logic            ce_i,
  input  wire logic [PS_W-1:0] prescale_i,
  output logic                 quantum_o
);

  logic [PS_W-1:0] count;
  wire             at_end = (count >= prescale_i);

  // Period is prescale+1 clocks; value 0 gives a tick every clock
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      count     <= '0;
      quantum_o <= 1'b0;
    end else if (ce_i) begin
      count     <= at_end ? '0 : count + 1'b1;
      quantum_o <= at_end;
    end
  end

endmodule

`default_nettype wire

// ### rtl/cgs_status_irq.sv
// General status, interrupt flags, object bookkeeping and prescaler of a
// CAN controller. Assumes bus-engine events arrive as same-clock pulses
// and that software uses the plain strobe port, one access per cycle.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Enable flag shows true controller state
// - Bus-off bit; only entry raises event
// - Error-passive bit never raises interrupt
// - Summary flag: any source except timer
// - Bus-off event only from error passive
// - Timer wrap flag; clear by one or handler
// - Buffer flag clears only after rewrites
// - Stuff fault flag on six equal bits
// - CRC fault flag on mismatch
// - Form fault flag on delimiter violations
// - Ack fault flag on missing dominant
// - General flags clear on writing one
// - Global enable gates summary interrupt
// - Separate source enables bits six to one
// - Timer wrap enable independent of global
// - Read-only in-use bit per object
// - In-use clears on done, disable, abort, standby
// - Six object enables; upper bits zero
// - Read-only per-object pending bits
// - Quantum equals prescale plus one clocks
// - Object pending from enabled flag
// - Object errors never set general faults
module cgs_status_irq
  import cgs_pkg::*;
#(
  parameter int unsigned NUM_OBJ = CGS_NUM_OBJ
) (
  input  wire logic         clk_sys_i,
  input  wire logic         rst_n_i,
  input  wire logic         ce_i,
  // Register port
  input  wire logic [3:0]   addr_i,
  input  wire logic [7:0]   wdata_i,
  input  wire logic         wr_i,
  input  wire logic         rd_i,
  output logic [7:0]        rdata_o,
  // Controller state from the channel
  input  wire logic         ctrl_enabled_i,
  input  wire logic         bus_off_i,
  input  wire logic         err_passive_i,
  input  wire logic         abort_req_i,
  input  wire logic         standby_i,
  input  wire logic         timer_handler_i,
  input  wire cgs_chan_ev_t chan_ev_i,
  input  wire logic         obj_err_recorded_i,
  input  wire cgs_obj_ev_t  obj_ev_i,
  // Outputs
  output logic              ctrl_irq_o,
  output logic              timer_irq_o,
  output logic              quantum_o,
  output logic [5:0]        baud_prescaler_o
);

  //////////////////////////////////////////////////////////////////////
  // State
  logic               enable_state_flag;
  logic               bus_off_state;
  logic               error_passive_state;
  logic               bus_off_event_flag;
  logic               timer_wrap_flag;
  logic               buffer_receive_done_flag;
  logic               stuff_fault_flag;
  logic               crc_fault_flag;
  logic               form_fault_flag;
  logic               ack_fault_flag;
  logic [7:0]         gien;
  logic [NUM_OBJ-1:0] object_in_use;
  logic [NUM_OBJ-1:0] object_irq_enable;
  logic [NUM_OBJ-1:0] obj_rx_flag;
  logic [NUM_OBJ-1:0] obj_tx_flag;
  logic [NUM_OBJ-1:0] obj_err_flag;
  logic [7:0]         prescale_reg;
  logic               buf_rewritten;

  //////////////////////////////////////////////////////////////////////
  // Decode
  wire wr_gi   = wr_i && (addr_i == CGS_OFS_GIFLAGS);
  wire wr_ie   = wr_i && (addr_i == CGS_OFS_GIEN);
  wire wr_oie  = wr_i && (addr_i == CGS_OFS_OIEN_LO);
  wire wr_ps   = wr_i && (addr_i == CGS_OFS_PRESCALE);

  wire global_irq_enable        = gien[CGS_IE_GLOBAL];
  wire bus_off_irq_enable       = gien[CGS_IE_BUSOFF];
  wire receive_irq_enable       = gien[CGS_IE_RX];
  wire transmit_irq_enable      = gien[CGS_IE_TX];
  wire object_error_irq_enable  = gien[CGS_IE_OBJERR];
  wire buffer_irq_enable        = gien[CGS_IE_BUF];
  wire general_error_irq_enable = gien[CGS_IE_GENERR];
  wire timer_wrap_irq_enable    = gien[CGS_IE_TWRAP];

  // Write-one clear strobes, one per general flag
  wire clr_bus_off_state  = wr_gi && wdata_i[CGS_GI_BUSOFF];
  wire clr_twrap = (wr_gi && wdata_i[CGS_GI_TWRAP])
                   || timer_handler_i;
  wire clr_buf   = wr_gi && wdata_i[CGS_GI_BUFRX]
                   && buf_rewritten;
  wire clr_stuff = wr_gi && wdata_i[CGS_GI_STUFF];
  wire clr_crc   = wr_gi && wdata_i[CGS_GI_CRC];
  wire clr_form  = wr_gi && wdata_i[CGS_GI_FORM];
  wire clr_ack   = wr_gi && wdata_i[CGS_GI_ACK];

  // General faults only when no object took the error
  wire gen_ok    = !obj_err_recorded_i;

  // Bus-off entry only from error passive
  wire bus_off_state_entry = bus_off_i && !bus_off_state
                    && error_passive_state;

  //////////////////////////////////////////////////////////////////////
  // Object pending and summary
  logic [NUM_OBJ-1:0] object_irq_pending;
  genvar g;
  generate
    for (g = 0; g < NUM_OBJ; g++) begin : g_obj
      // Pending needs a flagged cause with its class enable and mask
      assign object_irq_pending[g] = object_irq_enable[g] &&
        ((obj_rx_flag[g]  && receive_irq_enable) ||
         (obj_tx_flag[g]  && transmit_irq_enable) ||
         (obj_err_flag[g] && object_error_irq_enable));
    end
  endgenerate

  wire gen_fault_any = stuff_fault_flag || crc_fault_flag
                       || form_fault_flag || ack_fault_flag;
  // Summary excludes the timer wrap source; status bits never feed it
  wire any_interrupt_flag =
    (|object_irq_pending) ||
    (bus_off_event_flag && bus_off_irq_enable) ||
    (buffer_receive_done_flag && buffer_irq_enable) ||
    (gen_fault_any && general_error_irq_enable);

  assign ctrl_irq_o  = any_interrupt_flag && global_irq_enable;
  assign timer_irq_o = timer_wrap_flag && timer_wrap_irq_enable;

  //////////////////////////////////////////////////////////////////////
  // Channel state mirrors; enable flag follows the applied state
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      enable_state_flag   <= 1'b0;
      bus_off_state       <= 1'b0;
      error_passive_state <= 1'b0;
    end else if (ce_i) begin
      enable_state_flag   <= ctrl_enabled_i;
      bus_off_state       <= bus_off_i;
      error_passive_state <= err_passive_i;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // General flags: a set in the clear cycle wins
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      {bus_off_event_flag, timer_wrap_flag, buffer_receive_done_flag,
       stuff_fault_flag, crc_fault_flag, form_fault_flag,
       ack_fault_flag} <= CGS_RST_GIFLAGS[6:0];
    end else if (ce_i) begin
      bus_off_event_flag <= bus_off_state_entry
                            || (bus_off_event_flag && !clr_bus_off_state);
      timer_wrap_flag    <= chan_ev_i.timer_wrap
                            || (timer_wrap_flag && !clr_twrap);
      buffer_receive_done_flag <= chan_ev_i.buf_rx_done
        || (buffer_receive_done_flag && !clr_buf);
      stuff_fault_flag <= (chan_ev_i.stuff_fault && gen_ok)
                          || (stuff_fault_flag && !clr_stuff);
      crc_fault_flag   <= (chan_ev_i.crc_fault && gen_ok)
                          || (crc_fault_flag && !clr_crc);
      form_fault_flag  <= (chan_ev_i.form_fault && gen_ok)
                          || (form_fault_flag && !clr_form);
      ack_fault_flag   <= (chan_ev_i.ack_fault && gen_ok)
                          || (ack_fault_flag && !clr_ack);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Buffer rewrite tracker: armed by a burst, satisfied by rewrites
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      buf_rewritten <= 1'b0;
    end else if (ce_i) begin
      if (chan_ev_i.buf_rx_done) begin
        buf_rewritten <= 1'b0;
      end else if (chan_ev_i.buf_cfg_rewritten) begin
        buf_rewritten <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Software-written registers; reserved bits masked off
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      gien              <= CGS_RST_GIEN;
      object_irq_enable <= CGS_RST_OIEN[NUM_OBJ-1:0];
      prescale_reg      <= CGS_RST_PRESCALE;
    end else if (ce_i) begin
      if (wr_ie) begin
        gien <= wdata_i;
      end
      if (wr_oie) begin
        object_irq_enable <= wdata_i[NUM_OBJ-1:0];
      end
      if (wr_ps) begin
        // Reserved ends dropped, so a careless write does no harm
        prescale_reg <= {1'b0, wdata_i[6:1], 1'b0};
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Per-object in-use and cause flags; done and disable win over enable
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      object_in_use <= '0;
      obj_rx_flag   <= '0;
      obj_tx_flag   <= '0;
      obj_err_flag  <= '0;
    end else if (ce_i) begin
      if (abort_req_i || standby_i) begin
        object_in_use <= '0;
      end else begin
        object_in_use <= (object_in_use | obj_ev_i.cfg_on)
          & ~(obj_ev_i.rx_done | obj_ev_i.tx_done
              | obj_ev_i.cfg_off);
      end
      // Cause flags cleared when the object is reconfigured
      obj_rx_flag  <= obj_ev_i.rx_done
                      | (obj_rx_flag & ~obj_ev_i.cfg_on);
      obj_tx_flag  <= obj_ev_i.tx_done
                      | (obj_tx_flag & ~obj_ev_i.cfg_on);
      obj_err_flag <= obj_ev_i.err
                      | (obj_err_flag & ~obj_ev_i.cfg_on);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Read mux; unmapped addresses read zero
  logic [7:0] next_rdata;
  wire [7:0] pad_inuse = {{(8-NUM_OBJ){1'b0}}, object_in_use};
  wire [7:0] pad_oien  = {{(8-NUM_OBJ){1'b0}}, object_irq_enable};
  wire [7:0] pad_oist  = {{(8-NUM_OBJ){1'b0}}, object_irq_pending};
  wire [7:0] gi_word   = {any_interrupt_flag, bus_off_event_flag,
                          timer_wrap_flag, buffer_receive_done_flag,
                          stuff_fault_flag, crc_fault_flag,
                          form_fault_flag, ack_fault_flag};
  wire [7:0] st_word   = {5'h00, enable_state_flag, bus_off_state,
                          error_passive_state};

  always_comb begin
    unique case (addr_i)
      CGS_OFS_STATUS:   next_rdata = st_word;
      CGS_OFS_GIFLAGS:  next_rdata = gi_word;
      CGS_OFS_GIEN:     next_rdata = gien;
      CGS_OFS_INUSE_LO: next_rdata = pad_inuse;
      CGS_OFS_OIEN_LO:  next_rdata = pad_oien;
      CGS_OFS_OIST_LO:  next_rdata = pad_oist;
      CGS_OFS_PRESCALE: next_rdata = prescale_reg;
      default:          next_rdata = 8'h00;
    endcase
  end

  // Data valid only in the cycle after the read strobe
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rdata_o <= 8'h00;
    end else if (ce_i) begin
      rdata_o <= rd_i ? next_rdata : 8'h00;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Quantum tick from the prescaler
  assign baud_prescaler_o = prescale_reg[CGS_PS_LSB +: CGS_PS_W];

  cgs_quantum_gen #(
    .PS_W(CGS_PS_W)
  ) u_quantum (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .ce_i      (ce_i),
    .prescale_i(baud_prescaler_o),
    .quantum_o (quantum_o)
  );

endmodule

`default_nettype wire

// ### tb/cgs_chan_model.sv
// Bus-engine model: fault confinement levels and one-cycle event pulses.
// Assumes the bench gives one command with go_i and waits for it.
`timescale 1ns/1ps
`default_nettype none
module cgs_chan_model
  import cgs_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  input  wire logic       go_i,
  input  wire logic [3:0] cmd_i,
  output var cgs_chan_ev_t chan_ev_o,
  output logic            bus_off_o,
  output logic            err_passive_o
);
  // Codes 0..6 pulse one event; 8 passive, 9 bus off, 10 recover
  always_ff @(posedge clk_sys_i) begin
    chan_ev_o <= cgs_chan_ev_t'(7'h00);
    if (!rst_n_i) begin
      bus_off_o <= 1'b0;
      err_passive_o <= 1'b0;
    end else if (go_i) begin
      if (cmd_i < 4'h7) chan_ev_o <= cgs_chan_ev_t'(7'h40 >> cmd_i);
      if (cmd_i == 4'h8) err_passive_o <= 1'b1;
      // Passive level kept through entry so the edge is seen
      if (cmd_i == 4'h9) bus_off_o <= 1'b1;
      if (cmd_i == 4'ha) begin
        bus_off_o <= 1'b0;
        err_passive_o <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ### tb/cgs_status_irq_sva.sv
// Checker for the CAN status and interrupt block, bound to its ports.
// Assumes one clock domain and software writes seen on the port.
`timescale 1ns/1ps
`default_nettype none
module cgs_status_irq_sva
  import cgs_pkg::*;
(
  input wire logic         clk_sys_i,
  input wire logic         rst_n_i,
  input wire logic         ce_i,
  input wire logic [3:0]   addr_i,
  input wire logic [7:0]   wdata_i,
  input wire logic         wr_i,
  input wire logic         rd_i,
  input wire logic [7:0]   rdata_o,
  input wire logic         bus_off_i,
  input wire logic         err_passive_i,
  input wire logic         abort_req_i,
  input wire logic         standby_i,
  input wire logic         timer_handler_i,
  input wire cgs_chan_ev_t chan_ev_i,
  input wire logic         ctrl_irq_o,
  input wire logic         timer_irq_o,
  input wire logic         quantum_o,
  input wire logic [5:0]   baud_prescaler_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////////////////////////////////////
  // Shadows of enables and prescaler, rebuilt from port writes
  logic [7:0] gien_q;
  logic [5:0] ps_sh;
  logic [5:0] ps_q;
  logic [6:0] q_cnt;
  logic       q_ok;
  wire        gien_wr = ce_i && wr_i && addr_i == CGS_OFS_GIEN;
  wire        ps_wr   = ce_i && wr_i && addr_i == CGS_OFS_PRESCALE;
  wire        hold_clr = abort_req_i || standby_i;
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) gien_q <= 8'h00;
    else if (gien_wr) gien_q <= wdata_i;
  end
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) ps_sh <= 6'h00;
    else if (ps_wr) ps_sh <= wdata_i[6:1];
  end
  // Quantum spacing is judged only over periods with a steady prescaler
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || quantum_o) q_cnt <= 7'h00;
    else q_cnt <= q_cnt + 7'h01;
  end
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) q_ok <= 1'b0;
    else if (!ce_i || baud_prescaler_o != ps_q) q_ok <= 1'b0;
    else if (quantum_o) q_ok <= 1'b1;
  end
  always_ff @(posedge clk_sys_i) ps_q <= baud_prescaler_o;
  ////////////////////////////////////////////////////////////////////////
  property p_gien_rd;
    ce_i && rd_i && addr_i == CGS_OFS_GIEN |=> rdata_o == $past(gien_q);
  endproperty
  a_gien_rd: assert property (p_gien_rd) else $error("enable readback");
  property p_ps_out;
    baud_prescaler_o == ps_sh;
  endproperty
  a_ps_out: assert property (p_ps_out) else $error("prescaler output");
  property p_quantum;
    q_ok && ce_i && baud_prescaler_o == ps_q &&
      (quantum_o || q_cnt >= {1'b0, ps_q}) |-> quantum_o && q_cnt == {1'b0, ps_q};
  endproperty
  a_quantum: assert property (p_quantum) else $error("quantum period");
  property p_twrap;
    ce_i && chan_ev_i.timer_wrap && gien_q[CGS_IE_TWRAP] && !gien_wr
      |=> timer_irq_o;
  endproperty
  a_twrap: assert property (p_twrap) else $error("timer wrap request");
  property p_handler;
    ce_i && timer_handler_i && !chan_ev_i.timer_wrap |=> !timer_irq_o;
  endproperty
  a_handler: assert property (p_handler) else $error("handler clear");
  property p_ctrl_gate;
    ctrl_irq_o |-> gien_q[CGS_IE_GLOBAL];
  endproperty
  a_ctrl_gate: assert property (p_ctrl_gate) else $error("global gate");
  property p_tmr_gate;
    timer_irq_o |-> gien_q[CGS_IE_TWRAP];
  endproperty
  a_tmr_gate: assert property (p_tmr_gate) else $error("timer gate");
  property p_bus_off_state;
    ce_i && $rose(bus_off_i) && $past(err_passive_i) && err_passive_i &&
      gien_q[CGS_IE_GLOBAL] && gien_q[CGS_IE_BUSOFF] && !gien_wr |=> ctrl_irq_o;
  endproperty
  a_bus_off_state: assert property (p_bus_off_state) else $error("bus-off event");
  property p_inuse;
    ce_i && rd_i && addr_i == CGS_OFS_INUSE_LO && $past(hold_clr)
      |=> rdata_o == 8'h00;
  endproperty
  a_inuse: assert property (p_inuse) else $error("in-use clear");
  c_tmr: cover property (timer_irq_o);
  c_ctrl: cover property (ctrl_irq_o);
  c_q: cover property (quantum_o && q_ok);
endmodule
bind cgs_status_irq cgs_status_irq_sva u_sva (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .bus_off_i(bus_off_i), .err_passive_i(err_passive_i),
  .abort_req_i(abort_req_i), .standby_i(standby_i),
  .timer_handler_i(timer_handler_i), .chan_ev_i(chan_ev_i),
  .ctrl_irq_o(ctrl_irq_o), .timer_irq_o(timer_irq_o),
  .quantum_o(quantum_o), .baud_prescaler_o(baud_prescaler_o));
`default_nettype wire

// ### tb/cgs_status_irq_tb_top.sv
// Self-checking bench for the CAN status and interrupt block.
// Assumes the checker is bound by its own file; one clock of 250 MHz.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin #1; n_tests++; if ((gt) !== (ex)) begin \
  fail_count++; $display("CHECK FAILED %s exp %h got %h", nm, ex, gt); \
  end end
module cgs_status_irq_tb_top;
  import cgs_pkg::*;
  localparam logic [3:0] FL = CGS_OFS_GIFLAGS;
  localparam logic [3:0] IE = CGS_OFS_GIEN;
  localparam logic [3:0] IU = CGS_OFS_INUSE_LO;
  localparam int WD_CYC = 25000;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic ctrl_en = 1'b0;
  logic abort_req = 1'b0;
  logic standby = 1'b0;
  logic handler = 1'b0;
  logic obj_err = 1'b0;
  logic go = 1'b0;
  logic ce = 1'b1;
  logic [3:0] addr_i = 4'h0;
  logic [3:0] cmd = 4'h0;
  logic [7:0] wdata_i = 8'h00;
  logic [7:0] rdata_o;
  logic [7:0] lfsr = 8'h4f;
  logic [7:0] b;
  logic [5:0] m;
  logic [5:0] bps;
  logic bus_off, err_passive, ctrl_irq, timer_irq, quantum;
  cgs_obj_ev_t obj_ev = '0;
  cgs_obj_ev_t ob;
  cgs_chan_ev_t chan_ev;
  int fail_count = 0;
  int n_tests = 0;
  always #2 clk_sys_i = ~clk_sys_i;
  cgs_chan_model u_chan (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .go_i(go), .cmd_i(cmd), .chan_ev_o(chan_ev), .bus_off_o(bus_off),
    .err_passive_o(err_passive));
  cgs_status_irq uut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .ce_i(ce), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .ctrl_enabled_i(ctrl_en),
    .bus_off_i(bus_off), .err_passive_i(err_passive),
    .abort_req_i(abort_req), .standby_i(standby),
    .timer_handler_i(handler), .chan_ev_i(chan_ev),
    .obj_err_recorded_i(obj_err), .obj_ev_i(obj_ev),
    .ctrl_irq_o(ctrl_irq), .timer_irq_o(timer_irq), .quantum_o(quantum),
    .baud_prescaler_o(bps));
  ////////////////////////////////////////////////////////////////////////
  // Random source and expected summary bit (enables gate each source)
  function automatic logic [7:0] nxt(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction
  function automatic logic [7:0] gi_exp(input logic [7:0] f,
                                        input logic [7:0] e);
    logic s;
    s = (f[6] & e[6]) | (f[4] & e[2]) | ((|f[3:0]) & e[1]);
    return {s, f[6:0]};
  endfunction
  // Bus cycles; each ends with an idle edge so strobes never double up
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e,
                        input string n);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    `CHK(n, e, rdata_o)
    @(posedge clk_sys_i);
  endtask
  // Go drops once only, so a following call may raise it at the last edge
  task automatic ev(input logic [3:0] c);
    go <= 1'b1;
    cmd <= c;
    @(posedge clk_sys_i);
    go <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
  endtask
  task automatic obj(input cgs_obj_ev_t v);
    obj_ev <= v;
    @(posedge clk_sys_i);
    obj_ev <= '0;
    @(posedge clk_sys_i);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Watchdog sized well above the expected one thousand or so cycles
  initial begin
    #(WD_CYC * 4);
    fail_count++;
    wrap_up();
  end
  initial begin
    repeat (20) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    for (int a = 0; a < 16; a++) rd_chk(4'(a), 8'h00, "reset");
    wr(IU, 8'h3f);
    rd_chk(IU, 8'h00, "in-use ro");
    wr(CGS_OFS_PRESCALE, 8'h00);
    repeat (8) @(posedge clk_sys_i);
    for (int i = 0; i < 8; i++) begin
      lfsr = nxt(lfsr);
      wr(IE, lfsr);
      rd_chk(IE, lfsr, "gien");
      wr(CGS_OFS_OIEN_LO, lfsr & 8'h3f);
      rd_chk(CGS_OFS_OIEN_LO, lfsr & 8'h3f, "oien");
      wr(CGS_OFS_PRESCALE, lfsr & 8'h7e);
      rd_chk(CGS_OFS_PRESCALE, lfsr & 8'h7e, "prescale");
      `CHK("bps", lfsr[6:1], bps)
      repeat (70) @(posedge clk_sys_i);
    end
    $display("test registers done");
    wr(IE, 8'h00);
    for (int c = 0; c < 5; c++) begin
      b = (c == 4) ? 8'h20 : 8'h08 >> c;
      ev(4'(c));
      rd_chk(FL, b, "fault flag");
      wr(FL, 8'h00);
      rd_chk(FL, b, "zero write");
      wr(FL, b);
      rd_chk(FL, 8'h00, "one clear");
      obj_err <= 1'b1;
      ev(4'(c));
      obj_err <= 1'b0;
      rd_chk(FL, (c == 4) ? b : 8'h00, "object err");
      wr(FL, b);
    end
    // Clock enable low: the event pulse passes unseen, flags stay put
    ce <= 1'b0;
    ev(4'h0);
    ce <= 1'b1;
    rd_chk(FL, 8'h00, "ce freeze");
    $display("test flags done");
    wr(IE, 8'h82);
    ev(4'h0);
    rd_chk(FL, gi_exp(8'h08, 8'h82), "summary");
    `CHK("ctrl irq", 1'b1, ctrl_irq)
    ev(4'h4);
    rd_chk(FL, gi_exp(8'h28, 8'h82), "timer apart");
    `CHK("tmr off", 1'b0, timer_irq)
    wr(IE, 8'h01);
    `CHK("tmr on", 1'b1, timer_irq)
    `CHK("ctrl gated", 1'b0, ctrl_irq)
    handler <= 1'b1;
    @(posedge clk_sys_i);
    handler <= 1'b0;
    @(posedge clk_sys_i);
    rd_chk(FL, 8'h08, "handler");
    ev(4'h4);
    `CHK("tmr wrap", 1'b1, timer_irq)
    wr(FL, 8'h28);
    $display("test requests done");
    ctrl_en <= 1'b1;
    wr(IE, 8'hc0);
    ev(4'h9);
    rd_chk(CGS_OFS_STATUS, 8'h06, "status");
    rd_chk(FL, 8'h00, "direct bus_off_state");
    ev(4'ha);
    ev(4'h8);
    rd_chk(CGS_OFS_STATUS, 8'h05, "passive");
    rd_chk(FL, 8'h00, "passive quiet");
    ev(4'h9);
    rd_chk(FL, gi_exp(8'h40, 8'hc0), "bus_off_state event");
    wr(FL, 8'h40);
    repeat (5) @(posedge clk_sys_i);
    rd_chk(FL, 8'h00, "bus_off_state stay");
    ev(4'ha);
    ev(4'h5);
    wr(FL, 8'h10);
    rd_chk(FL, 8'h10, "buf kept");
    ev(4'h6);
    wr(FL, 8'h10);
    rd_chk(FL, 8'h00, "buf clear");
    $display("test status done");
    wr(IE, 8'ha0);
    wr(CGS_OFS_OIEN_LO, 8'h3f);
    ob = '0;
    ob.rx_done = 6'h21;
    obj(ob);
    rd_chk(CGS_OFS_OIST_LO, 8'h21, "pending");
    `CHK("obj irq", 1'b1, ctrl_irq)
    ob = '0;
    ob.cfg_on = 6'h21;
    obj(ob);
    rd_chk(CGS_OFS_OIST_LO, 8'h00, "pending gone");
    wr(IE, 8'h88);
    ob = '0;
    ob.err = 6'h04;
    ob.tx_done = 6'h08;
    obj(ob);
    rd_chk(CGS_OFS_OIST_LO, 8'h04, "err only");
    for (int i = 0; i < 4; i++) begin
      if (i[0]) abort_req <= 1'b1;
      else standby <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      rd_chk(IU, 8'h00, "held clear");
      abort_req <= 1'b0;
      standby <= 1'b0;
      lfsr = nxt(lfsr);
      m = lfsr[5:0];
      ob = '0;
      ob.cfg_on = m;
      obj(ob);
      rd_chk(IU, {2'b00, m}, "in use");
      ob = '0;
      ob.rx_done = m & 6'h15;
      ob.tx_done = m & 6'h02;
      ob.cfg_off = m & 6'h08;
      obj(ob);
      rd_chk(IU, {2'b00, m & 6'h20}, "done clear");
    end
    $display("test objects done");
    wrap_up();
  end
endmodule
`undef CHK
`default_nettype wire
